// ===== src/selftest_pkg.sv
package selftest_pkg;
  localparam int        CAL_WORDS   = 8;
  localparam int        IDX_W       = 3;
  localparam int        DATA_W      = 8;
  localparam int        ACC_W       = 12;
  localparam int        SQ_W        = 26;
  localparam int        TEMP_W      = 8;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
  // Deflection phase length per direction
  localparam real       DEFL_PHASE_US = 100.0;
  localparam real       CLK_MHZ       = 25.0;
  localparam int        DEFL_CYC    = int'(DEFL_PHASE_US * CLK_MHZ);
  localparam logic [11:0] DEFL_CYC_W = DEFL_CYC[11:0];
  localparam logic [ACC_W-1:0] DEFL_THR = 12'h100;
  localparam logic [SQ_W-1:0] GRAV_LO  = 26'h0030000;
  localparam logic [SQ_W-1:0] GRAV_HI  = 26'h0050000;
  localparam logic [SQ_W-1:0] DIAG_THR = 26'h0010000;

  typedef enum logic [5:0] {
    ST_LOAD   = 6'h01,
    ST_CHECK  = 6'h02,
    ST_DEFL_P = 6'h04,
    ST_DEFL_N = 6'h08,
    ST_GRAV   = 6'h10,
    ST_RUN    = 6'h20
  } state_t;
endpackage

// ===== src/accel_startup_selftest.sv
`timescale 1ns/1ps
`default_nettype none
module accel_startup_selftest (
  input  wire logic                                     clk,
  input  wire logic                                     reset,
  input  wire logic                                     shutdown,
  input  wire logic                                     cmd_checksum,
  input  wire logic                                     cmd_deflect,
  input  wire logic                                     cmd_gravity,
  input  wire logic                                     continuous_sensor_check,
  input  wire logic                                     multi_axis,
  input  wire logic [selftest_pkg::DATA_W-1:0]          nvm_data,
  input  wire logic [selftest_pkg::DATA_W-1:0]          nvm_checksum,
  input  wire logic signed [selftest_pkg::ACC_W-1:0]    acc_x,
  input  wire logic signed [selftest_pkg::ACC_W-1:0]    acc_y,
  input  wire logic signed [selftest_pkg::ACC_W-1:0]    acc_z,
  input  wire logic [selftest_pkg::SQ_W-1:0]            diag_value,
  input  wire logic [selftest_pkg::TEMP_W-1:0]          temp_raw,
  output logic [selftest_pkg::IDX_W-1:0]                nvm_addr,
  output logic [selftest_pkg::DATA_W-1:0]               cal_word,
  output logic [selftest_pkg::IDX_W-1:0]                cal_index,
  output logic                                          deflect_pos,
  output logic                                          deflect_neg,
  output logic                                          startup_done,
  output logic                                          mem_error,
  output logic                                          deflect_pass,
  output logic                                          startup_gravity_check,
  output logic                                          gravity_pass,
  output logic                                          gravity_done,
  output logic                                          cont_error,
  output logic                                          frame_error_bit,
  output logic signed [selftest_pkg::ACC_W-1:0]         acc_x_out,
  output logic signed [selftest_pkg::ACC_W-1:0]         acc_y_out,
  output logic signed [selftest_pkg::ACC_W-1:0]         acc_z_out,
  output logic [selftest_pkg::TEMP_W-1:0]               temp_out
);
  import selftest_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [5:0] raw;
  assign raw = {shutdown, cmd_checksum, cmd_deflect, cmd_gravity,
                continuous_sensor_check, multi_axis};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  logic sd;
  logic c_cs;
  logic c_df;
  logic c_gr;
  logic cont_en;
  logic multi;
  assign {sd, c_cs, c_df, c_gr, cont_en, multi} = s2_r;

  // Commands are edge-triggered so a held line asks only once
  logic [2:0] cmd_q_r;
  logic [2:0] cmd_q_nxt;
  logic       sd_q_r;
  logic       sd_q_nxt;
  logic       go_cs;
  logic       go_df;
  logic       go_gr;
  logic       leave_sd;
  always_comb begin
    cmd_q_nxt = {c_cs, c_df, c_gr};
    sd_q_nxt  = sd;
    go_cs     = c_cs & ~cmd_q_r[2];
    go_df     = c_df & ~cmd_q_r[1];
    go_gr     = c_gr & ~cmd_q_r[0];
    leave_sd  = sd_q_r & ~sd;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_q_r <= 3'h0;
      sd_q_r  <= 1'b0;
    end else begin
      cmd_q_r <= cmd_q_nxt;
      sd_q_r  <= sd_q_nxt;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  state_t                 st_r, st_nxt;
  logic [IDX_W-1:0]       idx_r, idx_nxt;
  logic [DATA_W-1:0]      sum_r, sum_nxt;
  logic [11:0]            tmr_r, tmr_nxt;
  logic                   seen_p_r, seen_p_nxt;
  logic                   seen_n_r, seen_n_nxt;
  logic                   done_r, done_nxt;
  logic                   memerr_r, memerr_nxt;
  logic                   dpass_r, dpass_nxt;
  logic                   gpass_r, gpass_nxt;
  logic                   gdone_r, gdone_nxt;
  logic                   cerr_r, cerr_nxt;
  logic                   load_r, load_nxt;
  logic [DATA_W-1:0]      calw_r, calw_nxt;
  logic [IDX_W-1:0]       cali_r, cali_nxt;
  logic [SQ_W-1:0]        res_sq;
  logic [SQ_W-1:0]        sx, sy, sz;
  logic [ACC_W-1:0]       ax_abs;

  always_comb begin
    sx     = SQ_W'(acc_x * acc_x);
    sy     = SQ_W'(acc_y * acc_y);
    sz     = SQ_W'(acc_z * acc_z);
    res_sq = sx + sy + sz;
    ax_abs = acc_x[ACC_W-1] ? ACC_W'(-acc_x) : acc_x;
  end

  always_comb begin
    st_nxt     = st_r;
    idx_nxt    = idx_r;
    sum_nxt    = sum_r;
    tmr_nxt    = tmr_r;
    seen_p_nxt = seen_p_r;
    seen_n_nxt = seen_n_r;
    done_nxt   = done_r;
    memerr_nxt = memerr_r;
    dpass_nxt  = dpass_r;
    gpass_nxt  = gpass_r;
    gdone_nxt  = gdone_r;
    cerr_nxt   = cerr_r;
    load_nxt   = load_r;
    calw_nxt   = calw_r;
    cali_nxt   = cali_r;
    case (st_r)
      ST_LOAD: begin
        // Full reload also on host recheck: working copy stays coherent
        calw_nxt = nvm_data;
        cali_nxt = idx_r;
        sum_nxt  = sum_r + nvm_data;
        idx_nxt  = idx_r + 1'b1;
        if (idx_r == IDX_LAST) begin
          st_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        memerr_nxt = (sum_r != nvm_checksum);
        idx_nxt    = '0;
        sum_nxt    = '0;
        if (load_r && !multi) begin
          st_nxt     = ST_DEFL_P;
          tmr_nxt    = DEFL_CYC_W;
          seen_p_nxt = 1'b0;
          seen_n_nxt = 1'b0;
        end else begin
          st_nxt = ST_RUN;
        end
        load_nxt = 1'b0;
      end
      ST_DEFL_P, ST_DEFL_N: begin
        tmr_nxt = tmr_r - 1'b1;
        if (ax_abs >= DEFL_THR) begin
          if (st_r == ST_DEFL_P) begin
            seen_p_nxt = 1'b1;
          end else begin
            seen_n_nxt = 1'b1;
          end
        end
        if (tmr_r == 12'h000) begin
          if (st_r == ST_DEFL_P) begin
            st_nxt  = ST_DEFL_N;
            tmr_nxt = DEFL_CYC_W;
          end else begin
            dpass_nxt = seen_p_r & (seen_n_r | (ax_abs >= DEFL_THR));
            st_nxt    = ST_RUN;
          end
        end
      end
      ST_GRAV: begin
        gpass_nxt = (res_sq >= GRAV_LO) && (res_sq <= GRAV_HI);
        gdone_nxt = 1'b1;
        st_nxt    = ST_RUN;
      end
      ST_RUN: begin
        done_nxt = 1'b1;
        if (go_cs) begin
          st_nxt = ST_LOAD;
        end else if (go_df && !multi) begin
          st_nxt     = ST_DEFL_P;
          tmr_nxt    = DEFL_CYC_W;
          seen_p_nxt = 1'b0;
          seen_n_nxt = 1'b0;
        end else if (go_gr && multi) begin
          gdone_nxt = 1'b0;
          st_nxt    = ST_GRAV;
        end
      end
      default: begin
        st_nxt = ST_LOAD;
      end
    endcase
    // Background test runs beside the sequencer; flag is sticky until disabled or shut down
    if (!cont_en) begin
      cerr_nxt = 1'b0;
    end else if (multi && done_r && diag_value > DIAG_THR) begin
      cerr_nxt = 1'b1;
    end
    if (sd || leave_sd) begin
      // Shutdown parks sequencer state and flags at reset values and keeps mem_error, while the cal word/index reload word 0; exit restarts start-up
      st_nxt     = ST_LOAD;
      idx_nxt    = '0;
      sum_nxt    = '0;
      tmr_nxt    = 12'h000;
      done_nxt   = 1'b0;
      dpass_nxt  = 1'b0;
      gpass_nxt  = 1'b0;
      gdone_nxt  = 1'b0;
      cerr_nxt   = 1'b0;
      load_nxt   = 1'b1;
      seen_p_nxt = 1'b0;
      seen_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r     <= ST_LOAD;
      idx_r    <= '0;
      sum_r    <= '0;
      tmr_r    <= 12'h000;
      seen_p_r <= 1'b0;
      seen_n_r <= 1'b0;
      done_r   <= 1'b0;
      memerr_r <= 1'b0;
      dpass_r  <= 1'b0;
      gpass_r  <= 1'b0;
      gdone_r  <= 1'b0;
      cerr_r   <= 1'b0;
      load_r   <= 1'b1;
      calw_r   <= '0;
      cali_r   <= '0;
    end else begin
      st_r     <= st_nxt;
      idx_r    <= idx_nxt;
      sum_r    <= sum_nxt;
      tmr_r    <= tmr_nxt;
      seen_p_r <= seen_p_nxt;
      seen_n_r <= seen_n_nxt;
      done_r   <= done_nxt;
      memerr_r <= memerr_nxt;
      dpass_r  <= dpass_nxt;
      gpass_r  <= gpass_nxt;
      gdone_r  <= gdone_nxt;
      cerr_r   <= cerr_nxt;
      load_r   <= load_nxt;
      calw_r   <= calw_nxt;
      cali_r   <= cali_nxt;
    end
  end

  // ****************************************
  // Result registers
  // ****************************************
  logic signed [ACC_W-1:0] ox_r, oy_r, oz_r, ox_nxt, oy_nxt, oz_nxt;
  logic [TEMP_W-1:0]       tp_r, tp_nxt;
  always_comb begin
    ox_nxt = done_r ? acc_x : ox_r;
    oy_nxt = done_r ? acc_y : oy_r;
    oz_nxt = done_r ? acc_z : oz_r;
    tp_nxt = temp_raw;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ox_r <= '0;
      oy_r <= '0;
      oz_r <= '0;
      tp_r <= '0;
    end else begin
      ox_r <= ox_nxt;
      oy_r <= oy_nxt;
      oz_r <= oz_nxt;
      tp_r <= tp_nxt;
    end
  end

  assign nvm_addr              = idx_r;
  assign cal_word              = calw_r;
  assign cal_index             = cali_r;
  assign deflect_pos           = (st_r == ST_DEFL_P);
  assign deflect_neg           = (st_r == ST_DEFL_N);
  assign startup_done          = done_r;
  assign mem_error             = memerr_r;
  assign deflect_pass          = dpass_r;
  assign startup_gravity_check = (st_r == ST_GRAV);
  assign gravity_pass          = gpass_r;
  assign gravity_done          = gdone_r;
  assign cont_error            = cerr_r;
  assign frame_error_bit       = cerr_r;
  assign acc_x_out             = ox_r;
  assign acc_y_out             = oy_r;
  assign acc_z_out             = oz_r;
  assign temp_out              = tp_r;
endmodule
`default_nettype wire

// ===== verification/sensor_nvm_model.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_nvm_model (
  input  wire logic [selftest_pkg::IDX_W-1:0]        nvm_addr,
  input  wire logic                                  deflect_pos,
  input  wire logic                                  deflect_neg,
  input  wire logic                                  corrupt,
  input  wire logic signed [selftest_pkg::ACC_W-1:0] amp,
  input  wire logic signed [selftest_pkg::ACC_W-1:0] rest,
  output logic [selftest_pkg::DATA_W-1:0]            nvm_data,
  output logic [selftest_pkg::DATA_W-1:0]            nvm_checksum,
  output logic signed [selftest_pkg::ACC_W-1:0]      acc_x
);
  import selftest_pkg::*;
  // ********
  // Memory and proof mass
  // ********
  // Words 0x03, 0x13 .. 0x73 wrap-sum to 0xd8
  assign nvm_data = {1'b0, nvm_addr, 4'h3};
  // One flipped bit stands in for a decayed cell
  assign nvm_checksum = corrupt ? 8'hd9 : 8'hd8;
  // Mass follows the drive at a set amplitude, no settling modelled
  assign acc_x = deflect_pos ? amp : (deflect_neg ? -amp : rest);
endmodule
`default_nettype wire

// ===== verification/accel_selftest_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module accel_selftest_asserts (
  input wire logic                              clk,
  input wire logic                              reset,
  input wire logic                              multi_axis,
  input wire logic                              continuous_sensor_check,
  input wire logic signed [selftest_pkg::ACC_W-1:0] acc_x,
  input wire logic [selftest_pkg::TEMP_W-1:0]   temp_raw,
  input wire logic [selftest_pkg::IDX_W-1:0]    nvm_addr,
  input wire logic                              deflect_pos,
  input wire logic                              deflect_neg,
  input wire logic                              startup_done,
  input wire logic                              startup_gravity_check,
  input wire logic                              gravity_done,
  input wire logic                              cont_error,
  input wire logic                              frame_error_bit,
  input wire logic signed [selftest_pkg::ACC_W-1:0] acc_x_out,
  input wire logic [selftest_pkg::TEMP_W-1:0]   temp_out
);
  import selftest_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ********
  // Properties
  // ********
  // Only the first edge after release starts the walk; the releasing edge still sees reset high
  a_load_walk: assert property ($fell(reset) |-> nvm_addr == 3'h0 ##7 nvm_addr == 3'h7)
    else $error("calibration load did not step through all words");
  a_mass_one_way: assert property (!(deflect_pos && deflect_neg))
    else $error("proof mass driven both ways at once");
  a_defl_single: assert property (deflect_pos || deflect_neg |-> !multi_axis)
    else $error("deflection on a multi-axis part");
  a_gravity_once: assert property (startup_gravity_check |=> !startup_gravity_check)
    else $error("gravity test ran twice for one request");
  a_gravity_multi: assert property (startup_gravity_check |-> multi_axis)
    else $error("gravity test on a single-axis part");
  a_gravity_answer: assert property (startup_gravity_check |-> ##[1:3] gravity_done)
    else $error("gravity test gave no result");
  // Disable passes a two-stage synchroniser first
  a_cont_off: assert property (!continuous_sensor_check [*5] |-> !cont_error)
    else $error("background error flag kept while disabled");
  a_frame_copy: assert property (frame_error_bit == cont_error)
    else $error("frame bit differs from error flag");
  a_acc_follow: assert property (startup_done && $past(startup_done) |-> acc_x_out == $past(acc_x))
    else $error("acceleration output does not follow input");
  a_temp_follow: assert property (!$past(reset) |-> temp_out == $past(temp_raw))
    else $error("temperature output does not follow input");
endmodule
bind accel_startup_selftest accel_selftest_asserts u_chk (.clk(clk), .reset(reset),
  .multi_axis(multi_axis), .continuous_sensor_check(continuous_sensor_check), .acc_x(acc_x),
  .temp_raw(temp_raw), .nvm_addr(nvm_addr), .deflect_pos(deflect_pos),
  .deflect_neg(deflect_neg), .startup_done(startup_done),
  .startup_gravity_check(startup_gravity_check), .gravity_done(gravity_done),
  .cont_error(cont_error), .frame_error_bit(frame_error_bit), .acc_x_out(acc_x_out),
  .temp_out(temp_out));
`default_nettype wire

// ===== verification/accel_startup_selftest_tb.sv
`timescale 1ns/1ps
`default_nettype none
module accel_startup_selftest_tb;
  import selftest_pkg::*;
  logic clk = 1'b0, reset = 1'b1, shutdown = 1'b0, corrupt = 1'b0;
  logic cont_en = 1'b0, multi = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic signed [ACC_W-1:0] amp = 12'h100, gx = 12'h000, acc_x, ax_o;
  logic signed [ACC_W-1:0] gy = 12'h000, gz = 12'h000, ay_o, az_o;
  logic [SQ_W-1:0] diag = 26'h0000000;
  logic [TEMP_W-1:0] temp = 8'h5a, temp_o;
  logic [DATA_W-1:0] nvm_data, nvm_sum, cal_word;
  logic [IDX_W-1:0] nvm_addr, cal_index;
  logic dpos, dneg, done, mem_err, dpass, gpass, gdone, cerr, ferr;
  int errors = 0, compares = 0;
  always #20 clk = ~clk;
  sensor_nvm_model u_far (.nvm_addr(nvm_addr), .deflect_pos(dpos), .deflect_neg(dneg),
    .corrupt(corrupt), .amp(amp), .rest(gx), .nvm_data(nvm_data), .nvm_checksum(nvm_sum),
    .acc_x(acc_x));
  accel_startup_selftest dut (.clk(clk), .reset(reset), .shutdown(shutdown),
    .cmd_checksum(cmd[0]), .cmd_deflect(cmd[1]), .cmd_gravity(cmd[2]),
    .continuous_sensor_check(cont_en), .multi_axis(multi), .nvm_data(nvm_data),
    .nvm_checksum(nvm_sum), .acc_x(acc_x), .acc_y(gy), .acc_z(gz),
    .diag_value(diag), .temp_raw(temp), .nvm_addr(nvm_addr), .cal_word(cal_word),
    .cal_index(cal_index), .deflect_pos(dpos), .deflect_neg(dneg), .startup_done(done),
    .mem_error(mem_err), .deflect_pass(dpass), .startup_gravity_check(),
    .gravity_pass(gpass), .gravity_done(gdone), .cont_error(cerr), .frame_error_bit(ferr),
    .acc_x_out(ax_o), .acc_y_out(ay_o), .acc_z_out(az_o), .temp_out(temp_o));
  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Commands are held one link period so the synchroniser cannot miss them
  task automatic pulse(input int which);
    @(posedge clk) cmd[which] <= 1'b1;
    tick(8);
    @(posedge clk) cmd[which] <= 1'b0;
    tick(8);
  endtask
  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (done !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
    check(done, 1'b1);
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    tick(16);
    @(posedge clk) reset <= 1'b0;
    wait_done(6000);
    check(mem_err, 1'b0);
    check(dpass, 1'b1);
    check({cal_index, cal_word}, 11'h773);
    check(temp_o, 8'h5a);
    // A gravity request on a single-axis part must be ignored
    pulse(2);
    check(gdone, 1'b0);
    @(posedge clk) gx <= 12'h123;
    tick(3);
    check(ax_o, 12'h123);
    @(posedge clk) corrupt <= 1'b1;
    pulse(0);
    wait_done(100);
    check(mem_err, 1'b1);
    check(dpass, 1'b1);
    @(posedge clk) corrupt <= 1'b0;
    pulse(0);
    wait_done(100);
    check(mem_err, 1'b0);
    // Amplitude one below the threshold, then exactly on it
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) amp <= i ? 12'h100 : 12'h0ff;
      pulse(1);
      tick(5100);
      check(dpass, i == 1);
    end
    @(posedge clk) shutdown <= 1'b1;
    tick(8);
    check({done, dpass}, 2'h0);
    @(posedge clk) shutdown <= 1'b0;
    tick(4);
    wait_done(6000);
    check(dpass, 1'b1);
    @(posedge clk) reset <= 1'b1;
    multi <= 1'b1;
    tick(4);
    @(posedge clk) reset <= 1'b0;
    wait_done(100);
    check(gdone, 1'b0);
    // x squared just above and just below the lower bound
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) gx <= i ? 12'h1bb : 12'h1bc;
      pulse(2);
      check({gdone, gpass}, {1'b1, i == 0});
    end
    // Resultant from y and z alone: exactly on the upper bound, then one step over
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) gx <= 12'h000;
      gy <= 12'h100;
      gz <= i ? 12'h201 : 12'h200;
      pulse(2);
      check({gdone, gpass}, {1'b1, i == 0});
    end
    check({ay_o, az_o}, {12'h100, 12'h201});
    // A deflection request on a multi-axis part must be ignored
    pulse(1);
    check({dpos, dneg}, 2'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) cont_en <= i != 3;
      diag <= (i == 1) ? 26'h0010001 : 26'h0010000;
      tick(8);
      check({ferr, cerr}, (i == 1 || i == 2) ? 2'h3 : 2'h0);
    end
    print_verdict();
  end
  initial begin
    #(40 * 40000);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
